// ### include/prp_regs.svh
`ifndef PRP_REGS_SVH
`define PRP_REGS_SVH
// Clock and timebase
`define PRP_CLK_HZ 20000000
`define PRP_TICK_MS 1
`define PRP_TICK_CYC ((`PRP_CLK_HZ / 1000) * `PRP_TICK_MS)
// Register byte offsets
`define PRP_OFF_CTRL 8'h00
`define PRP_OFF_TIMING 8'h04
`define PRP_OFF_POL 8'h08
`define PRP_OFF_DEFMSG 8'h0c
`define PRP_OFF_OUTCMD 8'h10
`define PRP_OFF_STATUS 8'h14
`define PRP_OFF_REQ 8'h18
`define PRP_OFF_DATA 8'h1c
`define PRP_OFF_AUTOMAP 8'h20
`define PRP_OFF_ACK 8'h24
// Control fields
`define PRP_CTRL_AUTO_LSB 0
`define PRP_CTRL_FMT_LSB 2
`define PRP_CTRL_ENC_LSB 5
`define PRP_CTRL_DEF_EN 7
`define PRP_CTRL_OUT_MODE 8
`define PRP_CTRL_OUT_POL 9
`define PRP_CTRL_OUT_DEF_LSB 16
// Output command fields
`define PRP_OCMD_OP_LSB 0
`define PRP_OCMD_TO_LSB 4
`define PRP_OCMD_VAL_LSB 8
// Reset values
`define PRP_CTRL_RST 32'h0000_0000
`define PRP_STROBE_MS_RST 8'h03
`define PRP_DEBOUNCE_RST 8'h01
`define PRP_POL_RST 10'h000
// Timing limits
`define PRP_STROBE_MS_MIN 8'h03
`define PRP_STROBE_MS_MAX 8'hfa
`define PRP_DEB_UNIT_MS 10
`define PRP_TO_MS_UNIT 10
`define PRP_TO_S_UNIT 1000
`define PRP_TO_M_UNIT 60000
`endif

// ### include/prp_pkg.sv
package prp_pkg;
    // Automatic request modes
    typedef enum logic [1:0] {AUTO_OFF, AUTO_EDGE, AUTO_VALUE, AUTO_RSVD} auto_request_mode_e;
    // Message number formats
    typedef enum logic [2:0] {FMT_BCD4, FMT_BCD8, FMT_BCD9, FMT_BIN4, FMT_BIN8} msg_fmt_e;
    // Embedded data encodings
    typedef enum logic [1:0] {ENC_ASCII, ENC_BCD, ENC_BIN} data_enc_e;
    // Output pin commands
    typedef enum logic [3:0] {
        OCMD_NONE, OCMD_ON, OCMD_OFF, OCMD_TOGGLE, OCMD_LOCK, OCMD_UNLOCK,
        OCMD_HALT, OCMD_RUN, OCMD_SET
    } out_cmd_e;
    // Timeout start units
    typedef enum logic [2:0] {TO_MS, TO_SEC, TO_MIN, TO_LATCH, TO_DEFAULT} to_unit_e;
endpackage

// ### hw/parallel_request_port.sv
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "prp_regs.svh"

module parallel_request_port #(
    parameter int TICK_CYC = `PRP_TICK_CYC
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    // Parallel port pins
    input wire logic [7:0] I_DATA,
    input wire logic I_MSG_DATA_SEL,
    input wire logic I_STROBE,
    output logic O_OUT_PIN,
    output logic O_OUT_PIN_OE,
    // Avalon-MM slave
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST
);
    // Configuration registers
    logic [31:0] ctrl;
    logic [7:0] strobe_ms;
    logic [7:0] deb_units;
    logic [9:0] pol;
    logic [7:0] def_msg;
    logic [15:0] auto_map;
    // Captured request and embedded data
    logic req_valid;
    logic req_is_data;
    logic [8:0] req_value;
    logic [8:0] nib_hold;
    logic nib_phase;
    // Input sampling
    logic [7:0] data_act;
    logic sel_act;
    logic stb_act;
    logic [7:0] last_port;
    // Timing
    logic [15:0] tick_cnt;
    logic tick;
    logic [7:0] stb_ms_cnt;
    logic [11:0] deb_cnt;
    logic stb_done;
    // Output pin state
    logic pin_on;
    logic pin_lock;
    logic to_run;
    logic to_latched;
    logic [31:0] to_ms;
    logic [1:0] auto_mode;
    logic [2:0] fmt;
    logic [1:0] enc;
    logic acc;
    logic wr_cmd;
    logic [3:0] cmd_op;
    logic [2:0] cmd_unit;
    logic [5:0] cmd_val;
    logic pin_level;

    typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_DEBOUNCE} port_state_e;
    port_state_e state;

    assign auto_mode = ctrl[`PRP_CTRL_AUTO_LSB +: 2];
    assign fmt = ctrl[`PRP_CTRL_FMT_LSB +: 3];
    assign enc = ctrl[`PRP_CTRL_ENC_LSB +: 2];
    assign acc = I_AVS_READ | I_AVS_WRITE;
    assign wr_cmd = I_AVS_WRITE && (I_AVS_ADDRESS == `PRP_OFF_OUTCMD);
    assign cmd_op = I_AVS_WRITEDATA[`PRP_OCMD_OP_LSB +: 4];
    assign cmd_unit = I_AVS_WRITEDATA[`PRP_OCMD_TO_LSB +: 3];
    assign cmd_val = I_AVS_WRITEDATA[`PRP_OCMD_VAL_LSB +: 6];

    assign data_act = I_DATA ^ pol[7:0];
    assign sel_act = I_MSG_DATA_SEL ^ pol[8];
    assign stb_act = I_STROBE ^ pol[9];

    // Bus answers in one cycle: waitrequest low only on the cycle after access
    // Writes act on that answering edge; read data is registered one edge earlier
    logic ack_q;
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc & ~ack_q;
        end
    end
    assign O_AVS_WAITREQUEST = acc & ~ack_q;

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tick_cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (tick_cnt == 16'(TICK_CYC - 1)) begin
            tick_cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

    // BCD decode of a nine bit field, one hundreds bit on top
    function automatic logic [8:0] bcd_dec(input logic [8:0] v);
        bcd_dec = 9'(v[8] * 100) + 9'(v[7:4] * 10) + 9'(v[3:0]);
    endfunction

    // Configuration writes, taken when waitrequest is low; only the timing register is limited to legal ranges
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl <= `PRP_CTRL_RST;
            strobe_ms <= `PRP_STROBE_MS_RST;
            deb_units <= `PRP_DEBOUNCE_RST;
            pol <= `PRP_POL_RST;
            def_msg <= 8'h00;
            auto_map <= 16'h0000;
        end else if (I_AVS_WRITE && ack_q) begin
            case (I_AVS_ADDRESS)
                `PRP_OFF_CTRL: ctrl <= I_AVS_WRITEDATA;
                `PRP_OFF_TIMING: begin
                    if (I_AVS_WRITEDATA[7:0] < `PRP_STROBE_MS_MIN) begin
                        strobe_ms <= `PRP_STROBE_MS_MIN;
                    end else if (I_AVS_WRITEDATA[7:0] > `PRP_STROBE_MS_MAX) begin
                        strobe_ms <= `PRP_STROBE_MS_MAX;
                    end else begin
                        strobe_ms <= I_AVS_WRITEDATA[7:0];
                    end
                    deb_units <= (I_AVS_WRITEDATA[15:8] == 8'h00) ? 8'h01
                                                                : I_AVS_WRITEDATA[15:8];
                end
                `PRP_OFF_POL: pol <= I_AVS_WRITEDATA[9:0];
                `PRP_OFF_DEFMSG: def_msg <= I_AVS_WRITEDATA[7:0];
                `PRP_OFF_AUTOMAP: auto_map <= I_AVS_WRITEDATA[15:0];
                default: ;
            endcase
        end
    end

    // Strobe qualification and debounce sequencer
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state <= ST_IDLE;
            stb_ms_cnt <= 8'h00;
            deb_cnt <= 12'h000;
            stb_done <= 1'b0;
        end else begin
            stb_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    stb_ms_cnt <= 8'h00;
                    // strobe starts sampling; change in auto mode
                    if ((auto_mode == prp_pkg::AUTO_OFF) ? stb_act
                        : (sel_act && data_act != last_port)) begin
                        state <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    // Strobe or changed value must hold the full width
                    if ((auto_mode == prp_pkg::AUTO_OFF) ? !stb_act
                        : (data_act == last_port || !sel_act)) begin
                        state <= ST_IDLE;
                    end else if (tick) begin
                        if (stb_ms_cnt + 8'h01 >= strobe_ms) begin
                            stb_done <= 1'b1;
                            deb_cnt <= 12'(deb_units * `PRP_DEB_UNIT_MS);
                            state <= ST_DEBOUNCE;
                        end
                        stb_ms_cnt <= stb_ms_cnt + 8'h01;
                    end
                end
                ST_DEBOUNCE: begin
                    if (tick) begin
                        if (deb_cnt <= 12'h001) begin
                            if (auto_mode != prp_pkg::AUTO_OFF || !stb_act) begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            deb_cnt <= deb_cnt - 12'h001;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Capture, decode and automatic request generation
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            req_valid <= 1'b0;
            req_is_data <= 1'b0;
            req_value <= 9'h000;
            nib_hold <= 9'h000;
            nib_phase <= 1'b0;
            last_port <= 8'h00;
        end else begin
            // A write to the acknowledge place clears it; a new capture wins
            if (I_AVS_WRITE && ack_q && I_AVS_ADDRESS == `PRP_OFF_ACK) begin
                req_valid <= 1'b0;
            end
            if (stb_done) begin
                last_port <= data_act;
                case (auto_mode)
                    prp_pkg::AUTO_EDGE: begin
                        // lowest changed line, rise or fall message
                        req_is_data <= 1'b0;
                        req_valid <= 1'b0;
                        for (int i = 7; i >= 0; i--) begin
                            if (data_act[i] != last_port[i]) begin
                                req_valid <= 1'b1;
                                req_value <= {data_act[i], 5'h00, 3'(i)};
                                // unused line uses fallback or nothing
                                if (!auto_map[{3'(i), ~data_act[i]}]) begin
                                    req_valid <= ctrl[`PRP_CTRL_DEF_EN];
                                    req_value <= {1'b0, def_msg};
                                end
                            end
                        end
                    end
                    prp_pkg::AUTO_VALUE: begin
                        req_is_data <= 1'b0;
                        req_valid <= 1'b1;
                        req_value <= {1'b0, data_act};
                    end
                    default: begin
                        req_is_data <= ~sel_act;
                        if (fmt == prp_pkg::FMT_BCD4 || fmt == prp_pkg::FMT_BIN4 ||
                            (!sel_act && enc != prp_pkg::ENC_BIN && fmt == prp_pkg::FMT_BCD4)) begin
                            // four bit transfers pair into a byte, high first, except bin4 message numbers which stand alone
                            if (!nib_phase && fmt == prp_pkg::FMT_BIN4 && sel_act) begin
                                req_valid <= 1'b1;
                                req_value <= {5'h00, data_act[3:0]};
                            end else if (!nib_phase) begin
                                nib_hold <= {5'h00, data_act[3:0]};
                                nib_phase <= 1'b1;
                            end else begin
                                nib_phase <= 1'b0;
                                req_valid <= 1'b1;
                                req_value <= (sel_act || enc == prp_pkg::ENC_BCD)
                                    ? bcd_dec({1'b0, nib_hold[3:0], data_act[3:0]})
                                    : {1'b0, nib_hold[3:0], data_act[3:0]};
                            end
                        end else begin
                            req_valid <= 1'b1;
                            // eight/nine bit forms; ninth (hundreds) bit always zero
                            if (sel_act && fmt == prp_pkg::FMT_BCD9) begin
                                // Hundreds line is not wired, so it reads as zero
                                req_value <= bcd_dec({1'b0, data_act});
                            end else if (sel_act && fmt == prp_pkg::FMT_BCD8) begin
                                req_value <= bcd_dec({1'b0, data_act});
                            end else if (!sel_act && enc == prp_pkg::ENC_BCD) begin
                                req_value <= bcd_dec({1'b0, data_act});
                            end else begin
                                req_value <= {1'b0, data_act};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Output pin mode, lock, on/off/toggle and timeout
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pin_on <= 1'b0;
            pin_lock <= 1'b0;
            to_run <= 1'b0;
            to_latched <= 1'b1;
            to_ms <= 32'h0000_0000;
        end else begin
            if (tick && to_run && !to_latched) begin
                if (to_ms <= 32'h0000_0001) begin
                    to_ms <= 32'h0000_0000;
                    to_run <= 1'b0;
                    pin_on <= 1'b0;
                end else begin
                    to_ms <= to_ms - 32'h0000_0001;
                end
            end
            if (wr_cmd && ack_q && ctrl[`PRP_CTRL_OUT_MODE]) begin
                if (cmd_op == prp_pkg::OCMD_UNLOCK) begin
                    pin_lock <= 1'b0;
                end else if (!pin_lock) begin
                    case (cmd_op)
                        prp_pkg::OCMD_ON: pin_on <= 1'b1;
                        prp_pkg::OCMD_OFF: pin_on <= 1'b0;
                        prp_pkg::OCMD_TOGGLE: pin_on <= ~pin_on;
                        prp_pkg::OCMD_LOCK: pin_lock <= 1'b1;
                        prp_pkg::OCMD_HALT: to_run <= 1'b0;
                        prp_pkg::OCMD_RUN: to_run <= 1'b1;
                        prp_pkg::OCMD_SET: begin
                            to_run <= 1'b1;
                            to_latched <= (cmd_unit == prp_pkg::TO_LATCH);
                            case (cmd_unit)
                                prp_pkg::TO_MS: to_ms <= 32'(cmd_val * `PRP_TO_MS_UNIT);
                                prp_pkg::TO_SEC: to_ms <= 32'(cmd_val * `PRP_TO_S_UNIT);
                                prp_pkg::TO_MIN: to_ms <= 32'(cmd_val * `PRP_TO_M_UNIT);
                                prp_pkg::TO_DEFAULT:
                                    to_ms <= 32'(ctrl[`PRP_CTRL_OUT_DEF_LSB +: 16]
                                                 * `PRP_TO_MS_UNIT);
                                default: to_ms <= 32'h0000_0000;
                            endcase
                        end
                        default: ;
                    endcase
                end
            end
        end
    end

    // busy or output mode with polarity; busy while collecting
    assign pin_level = ctrl[`PRP_CTRL_OUT_MODE] ? pin_on
                     : (state != ST_IDLE || req_valid || nib_phase);
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_OUT_PIN <= 1'b0;
            O_OUT_PIN_OE <= 1'b0;
        end else begin
            // Open collector: drive low when the level is asserted-low
            O_OUT_PIN <= 1'b0;
            O_OUT_PIN_OE <= pin_level ^ ctrl[`PRP_CTRL_OUT_POL];
        end
    end

    // Register read mux
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_AVS_READDATA <= 32'h0000_0000;
        end else if (I_AVS_READ && !ack_q) begin
            case (I_AVS_ADDRESS)
                `PRP_OFF_CTRL: O_AVS_READDATA <= ctrl;
                `PRP_OFF_TIMING: O_AVS_READDATA <= {16'h0000, deb_units, strobe_ms};
                `PRP_OFF_POL: O_AVS_READDATA <= {22'h0, pol};
                `PRP_OFF_DEFMSG: O_AVS_READDATA <= {24'h000000, def_msg};
                `PRP_OFF_STATUS: O_AVS_READDATA <= {24'h000000, (state != ST_IDLE),
                    nib_phase, to_latched, to_run, pin_lock, pin_on, req_is_data,
                    req_valid};
                `PRP_OFF_REQ: O_AVS_READDATA <= {22'h0, req_is_data, req_value};
                `PRP_OFF_DATA: O_AVS_READDATA <= to_ms;
                `PRP_OFF_AUTOMAP: O_AVS_READDATA <= {16'h0000, auto_map};
                default: O_AVS_READDATA <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verif/parallel_request_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_request_port_asserts #(
    parameter int TICK_CYC = 20000
) (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    // Port pins
    input wire logic [7:0] I_DATA,
    input wire logic I_MSG_DATA_SEL,
    input wire logic I_STROBE,
    input wire logic O_OUT_PIN,
    input wire logic O_OUT_PIN_OE,
    // Register bus
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);
    // Any bus request in flight
    logic req;
    assign req = I_AVS_READ | I_AVS_WRITE;
    pin_sink_only_a:
        assert property (!O_OUT_PIN) else $error("output pin driven high");
    reset_quiet_a:
        assert property ($rose(I_RESETN) |-> !O_OUT_PIN_OE && O_AVS_READDATA == 32'h0)
        else $error("outputs not quiet after reset");
    wait_first_a:
        assert property ($rose(req) |-> O_AVS_WAITREQUEST) else $error("no wait on new access");
    wait_bound_a:
        assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("wait held too long");
    wait_rearm_a:
        assert property (req && !O_AVS_WAITREQUEST ##1 req |-> O_AVS_WAITREQUEST)
        else $error("wait not raised between accesses");
    rdata_hold_a:
        assert property (!I_AVS_READ [*2] |-> $stable(O_AVS_READDATA))
        else $error("read data moved without a read");
    rdata_cause_a:
        assert property ($changed(O_AVS_READDATA) |-> $past(I_AVS_READ))
        else $error("read data changed with no read");
    unmapped_zero_a:
        assert property (I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS > 8'h24
            |-> O_AVS_READDATA == 32'h0) else $error("unmapped read not zero");
    // Main traffic seen at least once
    cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
    cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST);
    cover property ($rose(O_OUT_PIN_OE));
    cover property ($rose(I_STROBE));
endmodule

bind parallel_request_port parallel_request_port_asserts #(.TICK_CYC(TICK_CYC)) i_prp_asserts (
    .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_DATA(I_DATA),
    .I_MSG_DATA_SEL(I_MSG_DATA_SEL), .I_STROBE(I_STROBE), .O_OUT_PIN(O_OUT_PIN),
    .O_OUT_PIN_OE(O_OUT_PIN_OE), .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST));
`default_nettype wire

// ### verif/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
    // Clock and command from the bench
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_value,
    input wire logic i_sel,
    input wire logic [15:0] i_hold,
    input wire logic [15:0] i_gap,
    // Switch or controller lines
    output logic [7:0] o_data,
    output logic o_sel,
    output logic o_strobe,
    output logic o_busy
);
    // Lines idle low at power-up
    initial begin
        o_data = 8'h00;
        o_sel = 1'h0;
        o_strobe = 1'h0;
        o_busy = 1'h0;
    end
    // One transfer; a zero hold only moves the lines, as in automatic modes
    always @(posedge i_clk) begin
        if (i_go && !o_busy) begin
            o_busy <= 1'h1;
            o_data <= i_value;
            o_sel <= i_sel;
            repeat (2) @(posedge i_clk);
            if (i_hold != 16'h0000) begin
                o_strobe <= 1'h1;
                repeat (i_hold) @(posedge i_clk);
                o_strobe <= 1'h0;
            end
            repeat (i_gap) @(posedge i_clk);
            o_busy <= 1'h0;
        end
    end
endmodule
`default_nettype wire

// ### verif/parallel_request_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_request_port_tb_top;
    // Row: format, select, two nibbles, inverted data, bytes, expected request
    typedef struct packed {
        logic [2:0] fmt;
        logic sel;
        logic two;
        logic inv;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [9:0] exp;
    } row_s;
    // Short tick keeps ms timing cheap
    localparam int TICK = 20;
    // Held past 3 ticks with margin for tick phase
    localparam logic [15:0] HOLD = 16'h005a;
    localparam logic [15:0] GAP = 16'h00f0;
    logic clk, rstn, avs_read, avs_write, avs_waitrequest, out_pin, out_pin_oe;
    logic [7:0] avs_address, pdata, value;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic psel, pstrobe, sel, go, busy;
    logic [15:0] hold, gap;
    int n_fail, checks;
    row_s rows [7];
    parallel_request_port #(.TICK_CYC(TICK)) i_parallel_request_port (
        .I_SYS_CLK(clk), .I_RESETN(rstn), .I_DATA(pdata), .I_MSG_DATA_SEL(psel),
        .I_STROBE(pstrobe), .O_OUT_PIN(out_pin), .O_OUT_PIN_OE(out_pin_oe),
        .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read), .I_AVS_WRITE(avs_write),
        .I_AVS_WRITEDATA(avs_writedata), .O_AVS_READDATA(avs_readdata),
        .O_AVS_WAITREQUEST(avs_waitrequest));
    far_side_model i_far_side_model (
        .i_clk(clk), .i_go(go), .i_value(value), .i_sel(sel), .i_hold(hold), .i_gap(gap),
        .o_data(pdata), .o_sel(psel), .o_strobe(pstrobe), .o_busy(busy));
    // 20 MHz clock
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access; holds until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        if (n >= 20) begin
            n_fail++;
            $display("Error at %0t: bus answer missing", $time);
        end
    endtask
    // Hands one transfer to the far side and waits until it is idle
    task automatic send(input logic [7:0] v, input logic s, input logic [15:0] h,
                        input logic [15:0] g);
        int n;
        n = 0;
        @(posedge clk);
        value <= v;
        sel <= s;
        hold <= h;
        gap <= g;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        @(posedge clk);
        while (busy !== 1'h0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) begin
            n_fail++;
            $display("Error at %0t: far side stuck", $time);
        end
    endtask
    // Output command, then let the pin settle
    task automatic ocmd(input logic [31:0] c);
        bus(1'h1, 8'h10, c);
        repeat (3) @(posedge clk);
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end
    initial begin
        // Formats bcd4 0, bcd8 1, bcd9 2, bin4 3, bin8 4
        rows = '{'{3'h4, 1'h1, 1'h0, 1'h0, 8'ha5, 8'h00, 10'h0a5},
                 '{3'h4, 1'h1, 1'h0, 1'h1, 8'h5a, 8'h00, 10'h0a5},
                 '{3'h1, 1'h1, 1'h0, 1'h0, 8'h99, 8'h00, 10'h063},
                 '{3'h2, 1'h1, 1'h0, 1'h0, 8'h37, 8'h00, 10'h025},
                 '{3'h3, 1'h1, 1'h0, 1'h0, 8'h0a, 8'h00, 10'h00a},
                 '{3'h0, 1'h1, 1'h1, 1'h0, 8'h04, 8'h02, 10'h02a},
                 '{3'h4, 1'h0, 1'h0, 1'h0, 8'h3c, 8'h00, 10'h23c}};
        {rstn, avs_read, avs_write, go, sel} = 5'h00;
        {avs_address, value, avs_writedata, hold, gap} = 80'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        // Reset values, then an unmapped place that ignores writes
        bus(1'h0, 8'h04, 32'h0);
        chk(rd, 32'h0000_0103);
        bus(1'h1, 8'h3c, 32'hffff_ffff);
        bus(1'h0, 8'h3c, 32'h0);
        chk(rd, 32'h0);
        chk(32'(out_pin_oe), 32'h0);
        // Table of strobed requests, binary encoding for data
        foreach (rows[i]) begin
            bus(1'h1, 8'h08, rows[i].inv ? 32'h0000_00ff : 32'h0);
            bus(1'h1, 8'h00, 32'({rows[i].fmt, 2'h0}) | 32'h40);
            send(rows[i].d0, rows[i].sel, HOLD, GAP);
            if (rows[i].two) send(rows[i].d1, rows[i].sel, HOLD, GAP);
            bus(1'h0, 8'h18, 32'h0);
            chk(32'(rd[9:0]), 32'(rows[i].exp));
            chk(32'(out_pin_oe), 32'h1);
            bus(1'h1, 8'h24, 32'h0);
        end
        bus(1'h1, 8'h08, 32'h0);
        // Strobe shorter than the width is not taken
        send(8'h11, 1'h1, 16'h001e, GAP);
        bus(1'h0, 8'h14, 32'h0);
        chk(32'(rd[0]), 32'h0);
        // Value mode: change alone makes a request, select low blocks it
        bus(1'h1, 8'h00, 32'h0000_0052);
        send(8'h5a, 1'h1, 16'h0, 16'h0190);
        bus(1'h0, 8'h18, 32'h0);
        chk(32'(rd[9:0]), 32'h05a);
        bus(1'h1, 8'h24, 32'h0);
        send(8'hc3, 1'h0, 16'h0, 16'h0190);
        bus(1'h0, 8'h14, 32'h0);
        chk(32'(rd[0]), 32'h0);
        // Edge mode: line 2 going active names its line
        bus(1'h1, 8'h20, 32'h0000_ffff);
        bus(1'h1, 8'h00, 32'h0000_0051);
        send(8'hc3, 1'h1, 16'h0, 16'h0190);
        bus(1'h1, 8'h24, 32'h0);
        send(8'hc7, 1'h1, 16'h0, 16'h0190);
        bus(1'h0, 8'h18, 32'h0);
        chk(32'(rd[9:0]), 32'h102);
        // Unprogrammed line falling asks for the fallback message
        bus(1'h1, 8'h24, 32'h0);
        bus(1'h1, 8'h20, 32'h0);
        bus(1'h1, 8'h0c, 32'h0000_0077);
        bus(1'h1, 8'h00, 32'h0000_00d1);
        send(8'hc3, 1'h1, 16'h0, 16'h0190);
        bus(1'h0, 8'h18, 32'h0);
        chk(32'(rd[9:0]), 32'h077);
        // Output mode: on, locked off ignored, toggle, polarity
        bus(1'h1, 8'h00, 32'h0000_0100);
        ocmd(32'h1);
        chk(32'(out_pin_oe), 32'h1);
        ocmd(32'h4);
        ocmd(32'h2);
        chk(32'(out_pin_oe), 32'h1);
        ocmd(32'h5);
        ocmd(32'h3);
        chk(32'(out_pin_oe), 32'h0);
        bus(1'h1, 8'h00, 32'h0000_0300);
        repeat (3) @(posedge clk);
        chk(32'(out_pin_oe), 32'h1);
        bus(1'h1, 8'h00, 32'h0000_0100);
        // Timeout of 10 ms runs out; halted it waits, resumed it ends
        ocmd(32'h1);
        ocmd(32'h0000_0108);
        repeat (100) @(posedge clk);
        chk(32'(out_pin_oe), 32'h1);
        repeat (200) @(posedge clk);
        chk(32'(out_pin_oe), 32'h0);
        ocmd(32'h1);
        ocmd(32'h0000_0108);
        ocmd(32'h6);
        repeat (300) @(posedge clk);
        chk(32'(out_pin_oe), 32'h1);
        ocmd(32'h7);
        repeat (300) @(posedge clk);
        chk(32'(out_pin_oe), 32'h0);
        // Reset in mid-run drops the pin and the settings
        ocmd(32'h1);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        bus(1'h0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        chk(32'(out_pin_oe), 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
